//--- design/wdt_pkg.sv
// Package of constants for the watchdog timeout control block
package wdt_pkg;
    // Configuration space placement of the control register
    localparam logic [7:0]  AUX_DEVICE_NUMBER  = 8'h08;
    localparam logic [7:0]  CONTROL_INDEX      = 8'hf4;
    // Wishbone byte addresses (word aligned, index times four)
    localparam logic [11:0] ADDR_CONTROL       = 12'h3d0;
    localparam logic [11:0] ADDR_UNITS_SELECT  = 12'h3c4;
    localparam logic [11:0] ADDR_TIMEOUT_COUNT = 12'h3c8;
    localparam logic [11:0] ADDR_IRQ_STATUS    = 12'h400;
    localparam logic [11:0] ADDR_IRQ_MASK      = 12'h404;
    localparam logic [11:0] ADDR_DEVICE_SELECT = 12'h408;
    // Field positions of the control and units select registers
    localparam int          CTRL_STATUS_BIT    = 0;
    localparam int          CTRL_FORCE_BIT     = 2;
    localparam int          CTRL_KBC_EN_BIT    = 3;
    localparam int          UNITS_SECONDS_BIT  = 7;
    // Interrupt status bits
    localparam int          IRQ_EXPIRY_BIT     = 0;
    localparam int          IRQ_FORCE_BIT      = 1;
    localparam int          IRQ_KBC_BIT        = 2;
    localparam int          IRQ_BITS           = 3;
    // Reset values
    localparam logic [7:0]  CONTROL_RESET      = 8'h00;
    localparam logic [7:0]  UNITS_RESET        = 8'h00;
    localparam logic [7:0]  COUNT_RESET        = 8'h00;
    localparam logic [2:0]  MASK_RESET         = 3'h0;
    // Time base
    localparam longint      CLOCK_HZ           = 25000000;
    localparam longint      SECOND_S           = 1;
    localparam longint      MINUTE_S           = 60;
    localparam longint      SECOND_CYCLES      = CLOCK_HZ * SECOND_S;
endpackage : wdt_pkg

//--- design/wdt_edge_detect.sv
// Self-clearing rising edge detector for the keyboard trigger line
`timescale 1ns/100ps
module wdt_edge_detect
(
    // Clock and reset
    input  wire logic MCLK,
    input  wire logic RESET,
    // Line and result
    input  wire logic enable,
    input  wire logic line,
    output logic      pulse
);
    logic line_prev;
    logic next_line_prev;
    logic next_pulse;

    // One pulse per rising edge; a held high level never retriggers
    always_comb begin
        next_line_prev = line;
        next_pulse     = enable & line & ~line_prev;
    end

    // Registers; gating by enable drops all line activity when off
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            line_prev <= 1'b1;
            pulse     <= 1'b0;
        end else begin
            line_prev <= next_line_prev;
            pulse     <= next_pulse;
        end
    end
endmodule : wdt_edge_detect

//--- design/wdt_timebase.sv
// Timeout counter with minute or second units
`timescale 1ns/100ps
module wdt_timebase
    import wdt_pkg::*;
#(
    parameter longint SECOND_LEN = SECOND_CYCLES
)
(
    // Clock and reset
    input  wire logic       MCLK,
    input  wire logic       RESET,
    // Setup
    input  wire logic [7:0] count_value,
    input  wire logic       seconds_units,
    input  wire logic       restart,
    // Result
    output logic            expired
);
    logic [31:0] tick_count;
    logic [5:0]  sub_count;
    logic [7:0]  unit_count;
    logic        next_expired;
    logic [31:0] next_tick_count;
    logic [5:0]  next_sub_count;
    logic [7:0]  next_unit_count;
    logic        unit_done;

    // Prescaler to seconds, then to minutes when units select is clear
    always_comb begin
        next_tick_count = tick_count + 32'h1;
        next_sub_count  = sub_count;
        next_unit_count = unit_count;
        next_expired    = 1'b0;
        unit_done       = 1'b0;
        if (tick_count == 32'(SECOND_LEN - 1)) begin
            next_tick_count = 32'h0;
            if (seconds_units || sub_count == 6'(MINUTE_S - 1)) begin
                next_sub_count = 6'h0;
                unit_done      = 1'b1;
            end else begin
                next_sub_count = sub_count + 6'h1;
            end
        end
        if (unit_done) begin
            next_unit_count = unit_count + 8'h1;
        end
        // Zero count disables; expiry after count units, one pulse
        if (count_value != 8'h00 && unit_done && next_unit_count == count_value) begin
            next_expired = 1'b1;
        end
        if (restart || count_value == 8'h00 || next_expired) begin
            next_tick_count = 32'h0;
            next_sub_count  = 6'h0;
            next_unit_count = 8'h0;
        end
    end

    // Registers
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            tick_count <= 32'h0;
            sub_count  <= 6'h0;
            unit_count <= 8'h0;
            expired    <= 1'b0;
        end else begin
            tick_count <= next_tick_count;
            sub_count  <= next_sub_count;
            unit_count <= next_unit_count;
            expired    <= next_expired;
        end
    end
endmodule : wdt_timebase

//--- design/watchdog_timeout_control.sv
// Watchdog control register, timeout events and Wishbone slave
//
// Register access over Wishbone was left to the implementer.
`timescale 1ns/100ps
module watchdog_timeout_control
    import wdt_pkg::*;
#(
    parameter longint SECOND_LEN = SECOND_CYCLES
)
(
    // Clock and reset
    input  wire logic        MCLK,
    input  wire logic        RESET,
    // Wishbone slave
    input  wire logic        CYC_I,
    input  wire logic        STB_I,
    input  wire logic        WE_I,
    input  wire logic [11:0] ADR_I,
    input  wire logic [3:0]  SEL_I,
    input  wire logic [31:0] DAT_I,
    output logic [31:0]      DAT_O,
    output logic             ACK_O,
    // Keyboard controller trigger
    input  wire logic        KBC_TRIGGER_LINE,
    // Watchdog activity that restarts the count
    input  wire logic        WDT_RESTART,
    // Outputs
    output logic             WDT_TIMEOUT_EVENT,
    output logic             IRQ
);
    logic [7:0]          device_select;
    logic [7:0]          watchdog_control;
    logic [7:0]          watchdog_units_select_reg;
    logic [7:0]          watchdog_timeout_count;
    logic [IRQ_BITS-1:0] irq_status;
    logic [IRQ_BITS-1:0] irq_mask;
    logic                force_pending;
    logic                ack;
    logic [31:0]         read_data;

    logic [7:0]          next_device_select;
    logic [7:0]          next_watchdog_control;
    logic [7:0]          next_watchdog_units_select_reg;
    logic [7:0]          next_watchdog_timeout_count;
    logic [IRQ_BITS-1:0] next_irq_status;
    logic [IRQ_BITS-1:0] next_irq_mask;
    logic                next_force_pending;
    logic                next_ack;
    logic [31:0]         next_read_data;
    logic                next_event;

    logic                kbc_pulse;
    logic                expired;
    logic                bus_req;
    logic                wr_low;
    logic                aux_selected;
    logic [IRQ_BITS-1:0] event_vec;

    // Keyboard edge detector gated by the enable bit
    wdt_edge_detect u_edge (
        .MCLK   (MCLK),
        .RESET  (RESET),
        .enable (watchdog_control[CTRL_KBC_EN_BIT]),
        .line   (KBC_TRIGGER_LINE),
        .pulse  (kbc_pulse)
    );

    // Timeout counter
    wdt_timebase #(
        .SECOND_LEN (SECOND_LEN)
    ) u_timebase (
        .MCLK          (MCLK),
        .RESET         (RESET),
        .count_value   (watchdog_timeout_count),
        .seconds_units (watchdog_units_select_reg[UNITS_SECONDS_BIT]),
        .restart       (WDT_RESTART),
        .expired       (expired)
    );

    // Bus decode; a single-cycle ack, low byte lane only
    assign bus_req      = CYC_I & STB_I & ~ack;
    assign wr_low       = bus_req & WE_I & SEL_I[0];
    assign aux_selected = (device_select == AUX_DEVICE_NUMBER);
    assign event_vec    = {kbc_pulse, force_pending, expired};

    // Register next state
    always_comb begin
        next_device_select             = device_select;
        next_watchdog_control          = watchdog_control;
        next_watchdog_units_select_reg = watchdog_units_select_reg;
        next_watchdog_timeout_count    = watchdog_timeout_count;
        next_irq_mask                  = irq_mask;
        next_irq_status                = irq_status;
        next_force_pending             = 1'b0;
        next_ack                       = bus_req;
        next_read_data                 = 32'h0;
        // Force is OR of software and keyboard edge, plus expiry
        next_event = expired | force_pending | kbc_pulse;
        if (wr_low) begin
            case (ADR_I)
                ADDR_DEVICE_SELECT: next_device_select = DAT_I[7:0];
                ADDR_CONTROL: begin
                    if (aux_selected) begin
                        // Upper bits reserved, stored as zero
                        next_watchdog_control[CTRL_STATUS_BIT] = DAT_I[CTRL_STATUS_BIT];
                        next_watchdog_control[CTRL_KBC_EN_BIT] = DAT_I[CTRL_KBC_EN_BIT];
                        next_force_pending = DAT_I[CTRL_FORCE_BIT];
                    end
                end
                ADDR_UNITS_SELECT: begin
                    if (aux_selected) begin
                        next_watchdog_units_select_reg = DAT_I[7:0] & 8'h80;
                    end
                end
                ADDR_TIMEOUT_COUNT: begin
                    if (aux_selected) begin
                        next_watchdog_timeout_count = DAT_I[7:0];
                    end
                end
                ADDR_IRQ_STATUS: next_irq_status = irq_status & ~DAT_I[IRQ_BITS-1:0];
                ADDR_IRQ_MASK:   next_irq_mask   = DAT_I[IRQ_BITS-1:0];
                default:         next_irq_mask   = irq_mask;
            endcase
        end
        // Event wins over a write clearing the status in the same cycle
        if (next_event) begin
            next_watchdog_control[CTRL_STATUS_BIT] = 1'b1;
        end
        next_irq_status = next_irq_status | event_vec;
        if (bus_req && !WE_I) begin
            case (ADR_I)
                ADDR_DEVICE_SELECT: next_read_data = {24'h0, device_select};
                ADDR_CONTROL:       next_read_data = aux_selected ?
                                        {24'h0, watchdog_control} : 32'h0;
                ADDR_UNITS_SELECT:  next_read_data = aux_selected ?
                                        {24'h0, watchdog_units_select_reg} : 32'h0;
                ADDR_TIMEOUT_COUNT: next_read_data = aux_selected ?
                                        {24'h0, watchdog_timeout_count} : 32'h0;
                ADDR_IRQ_STATUS:    next_read_data = {29'h0, irq_status};
                ADDR_IRQ_MASK:      next_read_data = {29'h0, irq_mask};
                default:            next_read_data = 32'h0;
            endcase
        end
    end

    // State registers; reset stands in for the standby supply reset
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            device_select             <= 8'h00;
            watchdog_control          <= CONTROL_RESET;
            watchdog_units_select_reg <= UNITS_RESET;
            watchdog_timeout_count    <= COUNT_RESET;
            irq_status                <= '0;
            irq_mask                  <= MASK_RESET;
            force_pending             <= 1'b0;
            ack                       <= 1'b0;
            read_data                 <= 32'h0;
            WDT_TIMEOUT_EVENT         <= 1'b0;
        end else begin
            device_select             <= next_device_select;
            watchdog_control          <= next_watchdog_control;
            watchdog_units_select_reg <= next_watchdog_units_select_reg;
            watchdog_timeout_count    <= next_watchdog_timeout_count;
            irq_status                <= next_irq_status;
            irq_mask                  <= next_irq_mask;
            force_pending             <= next_force_pending;
            ack                       <= next_ack;
            read_data                 <= next_read_data;
            WDT_TIMEOUT_EVENT         <= next_event;
        end
    end

    // Outputs
    assign ACK_O = ack;
    assign DAT_O = read_data;
    assign IRQ   = |(irq_status & irq_mask);
endmodule : watchdog_timeout_control

//--- bench/wdt_checker_asserts.sv
// Port checker for the watchdog control block
`timescale 1ns/100ps
module wdt_checker import wdt_pkg::*;
(
    // Clock and reset
    input wire logic        MCLK,
    input wire logic        RESET,
    // Bus
    input wire logic        CYC_I,
    input wire logic        STB_I,
    input wire logic        WE_I,
    input wire logic [11:0] ADR_I,
    input wire logic [3:0]  SEL_I,
    input wire logic [31:0] DAT_I,
    input wire logic [31:0] DAT_O,
    input wire logic        ACK_O,
    // Trigger and results
    input wire logic        KBC_TRIGGER_LINE,
    input wire logic        WDT_TIMEOUT_EVENT,
    input wire logic        IRQ
);
    logic sel_ok;
    logic kbc_en;
    wire  wr_done = ACK_O && CYC_I && STB_I && WE_I && SEL_I[0];
    // Mirror select and enable; only then may events be demanded
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            sel_ok <= 1'b0;
            kbc_en <= 1'b0;
        end else if (wr_done && ADR_I == ADDR_DEVICE_SELECT) begin
            sel_ok <= DAT_I[7:0] == AUX_DEVICE_NUMBER;
        end else if (wr_done && sel_ok && ADR_I == ADDR_CONTROL) begin
            kbc_en <= DAT_I[CTRL_KBC_EN_BIT];
        end
    end
    default clocking @(posedge MCLK); endclocking
    default disable iff (RESET);
    // Bus handshake
    a_ack_one_cycle: assert property (ACK_O |=> !ACK_O)
        else $error("ack held longer than one cycle");
    a_ack_answers: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
        else $error("request not answered next cycle");
    a_ack_has_req: assert property (ACK_O |-> $past(CYC_I && STB_I))
        else $error("ack without request");
    a_dat_idle_zero: assert property (!ACK_O |-> DAT_O == 32'h0)
        else $error("read data not zero outside ack");
    a_ctrl_bits: assert property (ACK_O && !WE_I && ADR_I == ADDR_CONTROL
        |-> DAT_O[31:4] == 28'h0 && DAT_O[2:1] == 2'h0)
        else $error("control reads reserved or force bit set");
    // Timeout events
    a_force_event: assert property (wr_done && sel_ok && ADR_I == ADDR_CONTROL
        && DAT_I[CTRL_FORCE_BIT] |-> ##[0:3] WDT_TIMEOUT_EVENT)
        else $error("force write gave no event");
    a_kbc_event: assert property ($rose(KBC_TRIGGER_LINE) && kbc_en && sel_ok
        |-> ##[1:4] WDT_TIMEOUT_EVENT)
        else $error("trigger edge gave no event");
    a_quiet_reset: assert property ($fell(RESET)
        |-> !ACK_O && !IRQ && !WDT_TIMEOUT_EVENT)
        else $error("outputs active after reset");
    c_ctrl_write: cover property (wr_done && ADR_I == ADDR_CONTROL);
    c_kbc_event: cover property (WDT_TIMEOUT_EVENT && kbc_en);
    c_irq: cover property (IRQ);
endmodule : wdt_checker

bind watchdog_timeout_control wdt_checker i_chk (.MCLK, .RESET, .CYC_I, .STB_I,
    .WE_I, .ADR_I, .SEL_I, .DAT_I, .DAT_O, .ACK_O, .KBC_TRIGGER_LINE,
    .WDT_TIMEOUT_EVENT, .IRQ);

//--- bench/watchdog_timeout_control_bench.sv
// Self-checking bench for the watchdog control block
`timescale 1ns/100ps
module watchdog_timeout_control_bench import wdt_pkg::*;;
    typedef struct {logic [11:0] a; logic [31:0] w; logic [31:0] r;} row_t;
    localparam longint SLEN = 10;
    logic        MCLK = 1'b0;
    logic        RESET = 1'b1;
    logic        CYC_I = 1'b0;
    logic        STB_I = 1'b0;
    logic        WE_I = 1'b0;
    logic [11:0] ADR_I = 12'h0;
    logic [3:0]  SEL_I = 4'h0;
    logic [31:0] DAT_I = 32'h0;
    logic        KBC_TRIGGER_LINE = 1'b0;
    logic        WDT_RESTART = 1'b0;
    logic [31:0] DAT_O;
    logic        ACK_O;
    logic        WDT_TIMEOUT_EVENT;
    logic        IRQ;
    logic [31:0] rd;
    int          err_total = 0;
    int          tests_run = 0;
    int          events = 0;
    int          cycles = 0;
    int          base;
    // Write then read back; reserved bits and unmapped places read zero
    row_t rows [9] = '{
        '{ADDR_CONTROL, 32'h08, 32'h08},
        '{ADDR_CONTROL, 32'hf9, 32'h09},
        '{ADDR_CONTROL, 32'h00, 32'h00},
        '{ADDR_UNITS_SELECT, 32'h80, 32'h80},
        '{ADDR_UNITS_SELECT, 32'h7f, 32'h00},
        '{ADDR_TIMEOUT_COUNT, 32'hff, 32'hff},
        '{ADDR_TIMEOUT_COUNT, 32'h00, 32'h00},
        '{ADDR_IRQ_MASK, 32'h07, 32'h07},
        '{12'h0fc, 32'hff, 32'h00}
    };

    // Restart driven by the bench so a held restart can hold off expiry
    watchdog_timeout_control #(.SECOND_LEN(SLEN)) i_dut (.MCLK, .RESET, .CYC_I,
        .STB_I, .WE_I, .ADR_I, .SEL_I, .DAT_I, .DAT_O, .ACK_O, .KBC_TRIGGER_LINE,
        .WDT_RESTART, .WDT_TIMEOUT_EVENT, .IRQ);

    initial begin
        forever #20 MCLK = ~MCLK;
    end

    // Event counter and hang limit
    always @(posedge MCLK) begin
        cycles <= cycles + 1;
        if (WDT_TIMEOUT_EVENT === 1'b1) events <= events + 1;
        if (cycles == 5000) begin
            err_total++;
            test_done();
        end
    end

    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // One classic cycle; entered just after a rising edge
    task automatic wb(logic we, logic [11:0] a, logic [31:0] d);
        int n;
        n = 0;
        CYC_I <= 1'b1;
        STB_I <= 1'b1;
        WE_I  <= we;
        ADR_I <= a;
        SEL_I <= 4'hf;
        DAT_I <= d;
        do @(posedge MCLK); while (ACK_O !== 1'b1 && ++n < 20);
        if (n >= 20) err_total++;
        rd = DAT_O;
        CYC_I <= 1'b0;
        STB_I <= 1'b0;
        WE_I  <= 1'b0;
        @(posedge MCLK);
    endtask : wb

    task automatic rdchk(string name, logic [11:0] a, logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        check(name, rd, exp);
    endtask : rdchk

    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done

    initial begin
        repeat (4) @(posedge MCLK);
        RESET <= 1'b0;
        @(posedge MCLK);
        wb(1'b1, ADDR_DEVICE_SELECT, 32'h08);
        rdchk("control reset", ADDR_CONTROL, 32'(CONTROL_RESET));
        foreach (rows[i]) begin
            wb(1'b1, rows[i].a, rows[i].w);
            rdchk("register", rows[i].a, rows[i].r);
        end
        $display("register table done");
        // Software force with trigger disabled
        base = events;
        wb(1'b1, ADDR_CONTROL, 32'h04);
        repeat (3) @(posedge MCLK);
        check("force events", 32'(events - base), 32'h1);
        rdchk("status after force", ADDR_CONTROL, 32'h01);
        check("irq", {31'h0, IRQ}, 32'h1);
        rdchk("irq status", ADDR_IRQ_STATUS, 32'h2);
        wb(1'b1, ADDR_IRQ_STATUS, 32'h7);
        wb(1'b1, ADDR_CONTROL, 32'h00);
        check("irq cleared", {31'h0, IRQ}, 32'h0);
        $display("force test done");
        // Trigger ignored while disabled, one event per edge when enabled
        base = events;
        KBC_TRIGGER_LINE <= 1'b1;
        repeat (10) @(posedge MCLK);
        check("disabled trigger", 32'(events - base), 32'h0);
        KBC_TRIGGER_LINE <= 1'b0;
        wb(1'b1, ADDR_CONTROL, 32'h08);
        base = events;
        KBC_TRIGGER_LINE <= 1'b1;
        repeat (40) @(posedge MCLK);
        check("held trigger", 32'(events - base), 32'h1);
        rdchk("irq status kbc", ADDR_IRQ_STATUS, 32'h4);
        base = events;
        wb(1'b1, ADDR_CONTROL, 32'h0c);
        repeat (3) @(posedge MCLK);
        check("force with trigger", 32'(events - base), 32'h1);
        KBC_TRIGGER_LINE <= 1'b0;
        $display("trigger test done");
        // Expiry in seconds, disabled at zero, then minutes
        wb(1'b1, ADDR_UNITS_SELECT, 32'h80);
        base = events;
        wb(1'b1, ADDR_TIMEOUT_COUNT, 32'h01);
        repeat (15) @(posedge MCLK);
        check("second expiry", {31'h0, events > base}, 32'h1);
        wb(1'b1, ADDR_TIMEOUT_COUNT, 32'h00);
        base = events;
        repeat (40) @(posedge MCLK);
        check("count zero", 32'(events - base), 32'h0);
        // Held restart keeps the count from expiring
        WDT_RESTART <= 1'b1;
        wb(1'b1, ADDR_TIMEOUT_COUNT, 32'h01);
        base = events;
        repeat (30) @(posedge MCLK);
        check("held restart", 32'(events - base), 32'h0);
        WDT_RESTART <= 1'b0;
        repeat (15) @(posedge MCLK);
        check("after restart", 32'(events - base), 32'h1);
        wb(1'b1, ADDR_TIMEOUT_COUNT, 32'h00);
        wb(1'b1, ADDR_UNITS_SELECT, 32'h00);
        base = events;
        wb(1'b1, ADDR_TIMEOUT_COUNT, 32'h01);
        repeat (500) @(posedge MCLK);
        check("minute early", 32'(events - base), 32'h0);
        repeat (200) @(posedge MCLK);
        check("minute expiry", 32'(events - base), 32'h1);
        wb(1'b1, ADDR_TIMEOUT_COUNT, 32'h00);
        wb(1'b1, ADDR_DEVICE_SELECT, 32'h00);
        rdchk("deselected", ADDR_CONTROL, 32'h0);
        $display("expiry test done");
        test_done();
    end
endmodule : watchdog_timeout_control_bench
